// ### design/cce_top.sv
// condition evaluation and miscellaneous instruction core, wishbone slave
`timescale 1ns/1ps
module cce_top #(
  parameter int STACK_DEPTH = cce_pkg::STACK_DEPTH_DEF
) (
  // clock and reset
  input  logic        sys_clk,
  input  logic        srst,
  // wishbone slave
  input  logic        wb_cyc_i,
  input  logic        wb_stb_i,
  input  logic        wb_we_i,
  input  logic [7:0]  wb_adr_i,
  input  logic [3:0]  wb_sel_i,
  input  logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic        wb_ack_o,
  // unit status
  input  logic        alu_zero,
  input  logic        alu_neg,
  input  logic        alu_carry,
  input  logic        alu_ovf,
  input  logic        mult_ovf,
  input  logic        mult_sign,
  input  logic        shift_ovf,
  input  logic        shift_zero,
  input  logic [3:0]  external_input,
  // sequencer
  input  logic [31:0] seq_pc,
  input  logic        wake_irq,
  // results
  output logic        cond_pass_o,
  output logic        loop_done_o,
  output logic        xfer_stb_o,
  output logic [3:0]  dreg_sel_o,
  output logic        dreg_float_o,
  output logic [31:0] addr_o,
  output logic        bit_test_result_o,
  output logic        idle_o
);
  localparam int SPW = $clog2(STACK_DEPTH + 1);
  localparam logic [SPW-1:0] SP_FULL = SPW'(STACK_DEPTH);

  typedef struct packed {
    logic                          ack;
    logic [31:0]                   dat;
    logic [31:0]                   instr;
    logic [31:0]                   imm;
    logic [31:0]                   sreg;
    logic                          bit_test_result;
    logic                          pass;
    logic                          last_pass;
    logic                          done;
    logic                          idle;
    logic                          xfer;
    logic [3:0]                    dsel;
    logic                          dflt;
    logic [31:0]                   addr;
    logic [31:0]                   lcnt;
    logic [15:0][31:0]             idx;
    logic [15:0][31:0]             mdf;
    logic [STACK_DEPTH-1:0][31:0]  lstk;
    logic [SPW-1:0]                lsp;
    logic [STACK_DEPTH-1:0][32:0]  sstk;
    logic [SPW-1:0]                ssp;
    logic                          err;
  } cce_state_s;

  cce_state_s  st_reg;
  cce_state_s  st_next;
  cce_dec_if   dec_if ();
  logic [31:0] wr_word;
  logic [15:0] cbase;
  logic        req;
  logic        wr;
  logic        exec;
  logic        lce;
  logic        cond;

  cce_decode u_dec (
    .dif (dec_if.dec)
  );

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] reverse32(input logic [31:0] v);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31-i];
    end
    return r;
  endfunction

  // even code is the base condition, odd code its complement
  function automatic logic cond_eval(input logic [4:0] code, input logic [15:0] base);
    return base[code[4:1]] ^ code[0];
  endfunction

  assign wr_word = merge_bytes(st_reg.instr, wb_dat_i, wb_sel_i);
  assign dec_if.instr = wr_word;

  always_comb begin
    req = wb_cyc_i & wb_stb_i;
    // write lands on the edge where ack is seen high
    wr = req & wb_we_i & st_reg.ack;
    // idle ignores instructions until the wake irq
    exec = wr & (wb_adr_i == cce_pkg::REG_INSTR) & ~st_reg.idle;
    lce = (st_reg.lcnt == 32'h0000_0000);
    cbase = '0;
    cbase[cce_pkg::CB_ZERO] = alu_zero;
    cbase[cce_pkg::CB_NONNEG] = ~alu_neg;
    cbase[cce_pkg::CB_NONPOS] = alu_neg | alu_zero;
    cbase[cce_pkg::CB_ALU_CARRY] = alu_carry;
    cbase[cce_pkg::CB_ALU_OVF] = alu_ovf;
    cbase[cce_pkg::CB_MULT_OVF] = mult_ovf;
    cbase[cce_pkg::CB_MULT_SIGN] = mult_sign;
    cbase[cce_pkg::CB_SHIFT_OVF] = shift_ovf;
    cbase[cce_pkg::CB_SHIFT_ZERO] = shift_zero;
    for (int i = 0; i < 4; i++) begin
      cbase[cce_pkg::CB_FLAG0 + i] = external_input[i];
    end
    cbase[cce_pkg::CB_BIT_TEST] = st_reg.bit_test_result;
    // expired slot, complement while counts remain
    cbase[cce_pkg::CB_LOOP_EXP] = lce;
    // forever false, complement is always true
    cbase[cce_pkg::CB_FOREVER] = 1'b0;
    cond = cond_eval(dec_if.code, cbase);

    st_next = st_reg;
    st_next.ack = req & ~st_reg.ack;
    st_next.pass = 1'b0;
    st_next.done = 1'b0;
    st_next.xfer = 1'b0;
    // read data captured as ack rises; unmapped reads zero
    if (req & ~st_reg.ack & ~wb_we_i) begin
      st_next.dat = '0;
      case (wb_adr_i[7:6])
        cce_pkg::BANK_CTL: begin
          case (wb_adr_i)
            cce_pkg::REG_INSTR: st_next.dat = st_reg.instr;
            cce_pkg::REG_IMM:   st_next.dat = st_reg.imm;
            cce_pkg::REG_SREG:  st_next.dat = st_reg.sreg;
            cce_pkg::REG_LCNT:  st_next.dat = st_reg.lcnt;
            cce_pkg::REG_STAT: begin
              st_next.dat[cce_pkg::ST_PASS] = st_reg.last_pass;
              st_next.dat[cce_pkg::ST_DONE] = st_reg.done;
              st_next.dat[cce_pkg::ST_BTR] = st_reg.bit_test_result;
              st_next.dat[cce_pkg::ST_IDLE] = st_reg.idle;
              st_next.dat[cce_pkg::ST_ERR] = st_reg.err;
              st_next.dat[cce_pkg::ST_LCE] = lce;
            end
            default: st_next.dat = '0;
          endcase
        end
        cce_pkg::BANK_IDX: st_next.dat = st_reg.idx[wb_adr_i[5:2]];
        cce_pkg::BANK_MDF: st_next.dat = st_reg.mdf[wb_adr_i[5:2]];
        default:           st_next.dat = '0;
      endcase
    end
    if (wr) begin
      case (wb_adr_i[7:6])
        cce_pkg::BANK_CTL: begin
          case (wb_adr_i)
            cce_pkg::REG_INSTR: st_next.instr = wr_word;
            cce_pkg::REG_IMM:   st_next.imm = merge_bytes(st_reg.imm, wb_dat_i, wb_sel_i);
            cce_pkg::REG_SREG:  st_next.sreg = merge_bytes(st_reg.sreg, wb_dat_i, wb_sel_i);
            cce_pkg::REG_LCNT:  st_next.lcnt = merge_bytes(st_reg.lcnt, wb_dat_i, wb_sel_i);
            cce_pkg::REG_STAT: begin
              if (wb_sel_i[0] & wb_dat_i[cce_pkg::ST_ERR]) begin
                st_next.err = 1'b0;
              end
            end
            default: st_next.dat = st_next.dat;
          endcase
        end
        cce_pkg::BANK_IDX: begin
          st_next.idx[wb_adr_i[5:2]] =
            merge_bytes(st_reg.idx[wb_adr_i[5:2]], wb_dat_i, wb_sel_i);
        end
        cce_pkg::BANK_MDF: begin
          st_next.mdf[wb_adr_i[5:2]] =
            merge_bytes(st_reg.mdf[wb_adr_i[5:2]], wb_dat_i, wb_sel_i);
        end
        default: st_next.dat = st_next.dat;
      endcase
    end
    if (wake_irq) begin
      st_next.idle = 1'b0;
    end
    if (exec) begin
      case (dec_if.op)
        cce_pkg::OP_NOP: st_next.xfer = 1'b0;
        cce_pkg::OP_IDLE: st_next.idle = 1'b1;
        cce_pkg::OP_BIT: begin
          case (cce_pkg::cce_bit_e'(dec_if.sub))
            cce_pkg::BIT_SET: st_next.sreg = st_reg.sreg | st_reg.imm;
            cce_pkg::BIT_CLR: st_next.sreg = st_reg.sreg & ~st_reg.imm;
            cce_pkg::BIT_TGL: st_next.sreg = st_reg.sreg ^ st_reg.imm;
            cce_pkg::BIT_TST: st_next.bit_test_result = (st_reg.sreg & st_reg.imm) == st_reg.imm;
            cce_pkg::BIT_XOR: st_next.bit_test_result = (st_reg.sreg ^ st_reg.imm) == '0;
            default:          st_next.sreg = st_reg.sreg;
          endcase
        end
        cce_pkg::OP_MODIFY: begin
          st_next.idx[dec_if.idx_sel] = st_reg.idx[dec_if.idx_sel] + st_reg.imm;
        end
        cce_pkg::OP_REVERSE_BITS: begin
          st_next.idx[dec_if.idx_sel] = reverse32(st_reg.idx[dec_if.idx_sel] + st_reg.imm);
        end
        cce_pkg::OP_STACK: begin
          // loop stack holds the loop count
          if (dec_if.sub[cce_pkg::SUB_LOOP]) begin
            if (dec_if.sub[cce_pkg::SUB_PUSH]) begin
              if (st_reg.lsp == SP_FULL) begin
                st_next.err = 1'b1;
              end else begin
                st_next.lstk[st_reg.lsp] = st_reg.lcnt;
                st_next.lsp = st_reg.lsp + 1'b1;
              end
            end else if (st_reg.lsp == '0) begin
              st_next.err = 1'b1;
            end else begin
              st_next.lcnt = st_reg.lstk[st_reg.lsp - 1'b1];
              st_next.lsp = st_reg.lsp - 1'b1;
            end
          end
          // status stack holds test flag and system register
          if (dec_if.sub[cce_pkg::SUB_STS]) begin
            if (dec_if.sub[cce_pkg::SUB_PUSH]) begin
              if (st_reg.ssp == SP_FULL) begin
                st_next.err = 1'b1;
              end else begin
                st_next.sstk[st_reg.ssp] = {st_reg.bit_test_result, st_reg.sreg};
                st_next.ssp = st_reg.ssp + 1'b1;
              end
            end else if (st_reg.ssp == '0) begin
              st_next.err = 1'b1;
            end else begin
              {st_next.bit_test_result, st_next.sreg} = st_reg.sstk[st_reg.ssp - 1'b1];
              st_next.ssp = st_reg.ssp - 1'b1;
            end
          end
        end
        cce_pkg::OP_COND: begin
          st_next.pass = cond;
          st_next.last_pass = cond;
          // test and transfer in one instruction
          if (cond) begin
            st_next.xfer = 1'b1;
            st_next.dsel = dec_if.dreg_sel;
            st_next.dflt = dec_if.dreg_float;
            st_next.idx[dec_if.idx_sel] = st_reg.idx[dec_if.idx_sel] + st_reg.mdf[dec_if.mod_sel];
            if (dec_if.kind == cce_pkg::KIND_REL) begin
              st_next.addr = seq_pc + dec_if.imm_ext;
            end else begin
              st_next.addr = dec_if.imm_ext;
            end
          end
        end
        cce_pkg::OP_LOOP: begin
          // termination ends the loop, else count down, holding at zero
          st_next.done = cond;
          st_next.last_pass = cond;
          if (~cond & ~lce) begin
            st_next.lcnt = st_reg.lcnt - 32'h0000_0001;
          end
        end
        default: st_next.xfer = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.sreg <= cce_pkg::SREG_RST;
      st_reg.lcnt <= cce_pkg::LCNT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o          = st_reg.ack;
  assign wb_dat_o          = st_reg.dat;
  assign cond_pass_o       = st_reg.pass;
  assign loop_done_o       = st_reg.done;
  assign xfer_stb_o        = st_reg.xfer;
  assign dreg_sel_o        = st_reg.dsel;
  assign dreg_float_o      = st_reg.dflt;
  assign addr_o            = st_reg.addr;
  assign bit_test_result_o = st_reg.bit_test_result;
  assign idle_o            = st_reg.idle;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_cond(logic [4:0] c);
    exec && dec_if.op == cce_pkg::OP_COND && dec_if.code == c;
  endsequence
  sequence s_loop(logic [4:0] c);
    exec && dec_if.op == cce_pkg::OP_LOOP && dec_if.code == c;
  endsequence

  AST_ZERO_COND: assert property (
    s_cond(cce_pkg::CC_ZERO) |=> cond_pass_o == $past(alu_zero))
    else $error("zero condition wrong");
  AST_NEG_COND: assert property (
    s_cond(cce_pkg::CC_NEG) |=> cond_pass_o == $past(alu_neg))
    else $error("negative condition wrong");
  AST_GT_COND: assert property (
    s_cond(cce_pkg::CC_GT) |=> cond_pass_o == !($past(alu_neg) || $past(alu_zero)))
    else $error("positive condition wrong");
  AST_NCARRY_COND: assert property (
    s_cond(cce_pkg::CC_NALU_CARRY) |=> cond_pass_o != $past(alu_carry))
    else $error("not carry condition wrong");
  AST_SZERO_COND: assert property (
    s_cond(cce_pkg::CC_SHIFT_ZERO) |=> cond_pass_o == $past(shift_zero))
    else $error("shifter zero condition wrong");
  AST_FLAG2_COND: assert property (
    s_cond(cce_pkg::CC_FLAG2) |=> cond_pass_o == $past(external_input[2]))
    else $error("external input condition wrong");
  AST_LOOP_END: assert property (
    s_loop(cce_pkg::CC_LOOP_EXP) and lce |=> loop_done_o ##1 !loop_done_o)
    else $error("expired loop did not end");
  AST_TRUE_COND: assert property (
    s_cond(cce_pkg::CC_TRUE) |=> cond_pass_o && xfer_stb_o)
    else $error("true code did not execute");
  AST_FOREVER_LOOP: assert property (
    s_loop(cce_pkg::CC_FOREVER) |=> !loop_done_o)
    else $error("forever code ended a loop");
  AST_BIT_TEST: assert property (
    exec && dec_if.op == cce_pkg::OP_BIT && dec_if.sub == cce_pkg::BIT_TST
    |=> bit_test_result_o == (($past(st_reg.sreg) & $past(st_reg.imm)) == $past(st_reg.imm)))
    else $error("bit test flag wrong");
  AST_IDLE_HOLD: assert property (
    exec && dec_if.op == cce_pkg::OP_IDLE ##1 !wake_irq [*2] |-> idle_o)
    else $error("idle released without irq");
endmodule

// ### design/cce_pkg.sv
// shared constants and types of the condition code evaluator
package cce_pkg;
  // register byte offsets
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_IMM   = 8'h04;
  localparam logic [7:0] REG_SREG  = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0c;
  localparam logic [7:0] REG_LCNT  = 8'h10;
  localparam logic [1:0] BANK_CTL  = 2'h0;
  localparam logic [1:0] BANK_IDX  = 2'h1;
  localparam logic [1:0] BANK_MDF  = 2'h2;
  // reset values
  localparam logic [31:0] SREG_RST = 32'h0000_0000;
  localparam logic [31:0] LCNT_RST = 32'h0000_0000;
  localparam int STACK_DEPTH_DEF = 4;
  localparam int IMM_N = 6;
  // instruction word fields
  localparam int OP_HI = 31, OP_LO = 29, CODE_HI = 28, CODE_LO = 24;
  localparam int SUB_HI = 22, SUB_LO = 20, GEN_BIT = 19, IDX_HI = 18, IDX_LO = 16;
  localparam int FLT_BIT = 15, MOD_HI = 14, MOD_LO = 12, DREG_HI = 11, DREG_LO = 8;
  localparam int KIND_HI = 7, KIND_LO = 6, IMM_HI = 5, IMM_LO = 0;
  // stack sub-field bits
  localparam int SUB_PUSH = 2, SUB_LOOP = 1, SUB_STS = 0;
  // status register bits
  localparam int ST_PASS = 0, ST_DONE = 1, ST_BTR = 2, ST_IDLE = 3, ST_ERR = 4, ST_LCE = 5;
  // condition base slots; odd code = complement of even code
  localparam int CB_ZERO = 0, CB_NONNEG = 1, CB_NONPOS = 2, CB_ALU_CARRY = 3;
  localparam int CB_ALU_OVF = 4, CB_MULT_OVF = 5, CB_MULT_SIGN = 6, CB_SHIFT_OVF = 7;
  localparam int CB_SHIFT_ZERO = 8, CB_FLAG0 = 9, CB_BIT_TEST = 13, CB_LOOP_EXP = 14;
  localparam int CB_FOREVER = 15;
  localparam logic [4:0] CC_ZERO = 5'h00, CC_NEG = 5'h03, CC_GT = 5'h05;
  localparam logic [4:0] CC_NALU_CARRY = 5'h07, CC_SHIFT_ZERO = 5'h10, CC_FLAG2 = 5'h16;
  localparam logic [4:0] CC_LOOP_EXP = 5'h1c, CC_FOREVER = 5'h1e, CC_TRUE = 5'h1f;
  typedef enum logic [2:0] {
    OP_NOP = 3'h0, OP_IDLE = 3'h1, OP_BIT = 3'h2, OP_MODIFY = 3'h3,
    OP_REVERSE_BITS = 3'h4, OP_STACK = 3'h5, OP_COND = 3'h6, OP_LOOP = 3'h7
  } cce_op_e;
  typedef enum logic [2:0] {
    BIT_SET = 3'h0, BIT_CLR = 3'h1, BIT_TGL = 3'h2, BIT_TST = 3'h3, BIT_XOR = 3'h4
  } cce_bit_e;
  typedef enum logic [1:0] {
    KIND_DATA = 2'h0, KIND_ABS = 2'h1, KIND_REL = 2'h2
  } cce_kind_e;
endpackage

// ### design/cce_dec_if.sv
// decoded instruction fields between core and decoder
`timescale 1ns/1ps
interface cce_dec_if;
  logic [31:0]       instr;
  cce_pkg::cce_op_e  op;
  logic [4:0]        code;
  logic [2:0]        sub;
  logic [3:0]        idx_sel;
  logic [3:0]        mod_sel;
  logic [3:0]        dreg_sel;
  logic              dreg_float;
  cce_pkg::cce_kind_e kind;
  logic [31:0]       imm_ext;
  modport dec (input instr, output op, code, sub, idx_sel, mod_sel, dreg_sel,
               dreg_float, kind, imm_ext);
  modport core (output instr, input op, code, sub, idx_sel, mod_sel, dreg_sel,
                dreg_float, kind, imm_ext);
endinterface

// ### design/cce_decode.sv
// operand field decoder of the instruction word
`timescale 1ns/1ps
module cce_decode (
  // decoded fields
  cce_dec_if.dec dif
);
  logic [cce_pkg::IMM_N-1:0] raw;
  always_comb begin
    raw = dif.instr[cce_pkg::IMM_HI:cce_pkg::IMM_LO];
    dif.op = cce_pkg::cce_op_e'(dif.instr[cce_pkg::OP_HI:cce_pkg::OP_LO]);
    dif.code = dif.instr[cce_pkg::CODE_HI:cce_pkg::CODE_LO];
    dif.sub = dif.instr[cce_pkg::SUB_HI:cce_pkg::SUB_LO];
    dif.idx_sel = {dif.instr[cce_pkg::GEN_BIT], dif.instr[cce_pkg::IDX_HI:cce_pkg::IDX_LO]};
    // bit reverse only on first bank
    if (dif.op == cce_pkg::OP_REVERSE_BITS) begin
      dif.idx_sel[3] = 1'b0;
    end
    dif.mod_sel = {dif.instr[cce_pkg::GEN_BIT], dif.instr[cce_pkg::MOD_HI:cce_pkg::MOD_LO]};
    dif.dreg_sel = dif.instr[cce_pkg::DREG_HI:cce_pkg::DREG_LO];
    dif.dreg_float = dif.instr[cce_pkg::FLT_BIT];
    dif.kind = cce_pkg::cce_kind_e'(dif.instr[cce_pkg::KIND_HI:cce_pkg::KIND_LO]);
    if (dif.kind == cce_pkg::KIND_REL) begin
      dif.imm_ext = {{(32-cce_pkg::IMM_N){raw[cce_pkg::IMM_N-1]}}, raw};
    end else begin
      dif.imm_ext = {{(32-cce_pkg::IMM_N){1'b0}}, raw};
    end
  end
endmodule

// ### verif/cce_unit_model.sv
// partner model: status of the computation units and the sequencer pc
`timescale 1ns/1ps
module cce_unit_model (
  // clock
  input  wire logic        sys_clk,
  // status the bench asks for
  input  wire logic [11:0] pattern,
  input  wire logic [31:0] pc_set,
  // status towards the block
  output logic      [7:0]  unit_st,
  output logic      [3:0]  ext_in,
  output logic      [31:0] seq_pc
);
  // units settle on an edge, so the block only sees latest status one cycle later
  always_ff @(posedge sys_clk) begin
    unit_st <= pattern[7:0];
    ext_in  <= pattern[11:8];
    seq_pc  <= pc_set;
  end
endmodule

// ### verif/condition_code_evaluator_tb_top.sv
// self-checking bench of the condition code evaluator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module condition_code_evaluator_tb_top;
  logic        sys_clk = 1'b0, srst = 1'b1, cyc = 1'b0, we = 1'b0, wake = 1'b0;
  logic [7:0]  adr = 8'h00, st;
  logic [31:0] wdat = 32'h0, rdat, pc_set = 32'h0, dat_o, addr, pc;
  logic [11:0] pat = 12'h000;
  logic [3:0]  ext, dsel;
  logic        ack, pass, done, xfer, dfl, btr, idle;
  int          miscompares = 0, n_compared = 0, cycles = 0;
  always #12.5 sys_clk = ~sys_clk;
  cce_unit_model units (.sys_clk(sys_clk), .pattern(pat), .pc_set(pc_set),
    .unit_st(st), .ext_in(ext), .seq_pc(pc));
  cce_top dut (.sys_clk(sys_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .alu_zero(st[0]), .alu_neg(st[1]), .alu_carry(st[2]),
    .alu_ovf(st[3]), .mult_ovf(st[4]), .mult_sign(st[5]), .shift_ovf(st[6]),
    .shift_zero(st[7]), .external_input(ext), .seq_pc(pc),
    .wake_irq(wake), .cond_pass_o(pass), .loop_done_o(done), .xfer_stb_o(xfer),
    .dreg_sel_o(dsel), .dreg_float_o(dfl), .addr_o(addr),
    .bit_test_result_o(btr), .idle_o(idle));
  // one classic cycle; returns just after the ack edge so pulses can be seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0; we <= 1'b0;
    #1;
  endtask
  function automatic logic [31:0] ins(input logic [2:0] op, input logic [4:0] c,
      input logic [23:0] r);
    return {op, c, r};
  endfunction
  // expected truth of a code; odd codes are complements, 31 always true
  function automatic logic cexp(input logic [4:0] c, input logic [11:0] p, input logic lz);
    logic [15:0] b;
    b = {1'b0, lz, 1'b0, p[11:8], p[7:2], p[1] | p[0], ~p[1], p[0]};
    return (c == 5'h1f) ? 1'b1 : (b[c[4:1]] ^ c[0]);
  endfunction
  task automatic t_regs;
    logic [7:0] a[4] = '{8'h08, 8'h10, 8'h0c, 8'hfc};
    foreach (a[i]) begin
      wb(1'b0, a[i], 32'h0);
      `CHK("reset reg", (a[i] == 8'h0c) ? 32'h20 : 32'h0, rdat)
    end
    $display("done: regs");
  endtask
  task automatic t_cond;
    logic [11:0] ps[3] = '{12'h000, 12'h0a5, 12'hf5a};
    foreach (ps[k]) begin
      @(posedge sys_clk) pat <= ps[k];
      repeat (3) @(posedge sys_clk);
      for (int c = 0; c < 32; c++) begin
        wb(1'b1, 8'h00, ins(cce_pkg::OP_COND, c[4:0], 24'h0));
        `CHK("cond", cexp(c[4:0], ps[k], 1'b1), pass)
        `CHK("xfer", cexp(c[4:0], ps[k], 1'b1), xfer)
      end
    end
    $display("done: cond");
  endtask
  task automatic t_xfer;
    @(posedge sys_clk) pc_set <= 32'h1000;
    repeat (2) @(posedge sys_clk);
    wb(1'b1, 8'h00, ins(cce_pkg::OP_COND, 5'h1f, 24'h0085aa));
    `CHK("dreg", 5'h15, {dfl, dsel})
    // offset field 6'h2a is negative, so the target lies below the pc
    `CHK("rel addr", 32'h0000_0fea, addr)
    wb(1'b1, 8'h00, ins(cce_pkg::OP_COND, 5'h1f, 24'h00056a));
    `CHK("abs addr", 32'h2a, addr)
    $display("done: xfer");
  endtask
  task automatic t_bit;
    logic [2:0]  sb[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4};
    logic [31:0] mk[6] = '{32'h0f0f0000, 32'h00000f00, 32'hffffffff, 32'hf0f00000,
                           32'h00001234, 32'hf0f00fff};
    logic [31:0] sr[6] = '{32'h0f0fff00, 32'h0f0ff000, 32'hf0f00fff, 32'hf0f00fff,
                           32'hf0f00fff, 32'hf0f00fff};
    logic        flag_exp[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    wb(1'b1, 8'h08, 32'h0000ff00);
    foreach (sb[i]) begin
      wb(1'b1, 8'h04, mk[i]);
      wb(1'b1, 8'h00, ins(cce_pkg::OP_BIT, 5'h0, {1'b0, sb[i], 20'h0}));
      `CHK("bit test", flag_exp[i], btr)
      wb(1'b0, 8'h08, 32'h0);
      `CHK("sreg", sr[i], rdat)
    end
    $display("done: bit");
  endtask
  task automatic t_mod;
    wb(1'b1, 8'h4c, 32'h100);
    wb(1'b1, 8'h6c, 32'h200);
    wb(1'b1, 8'h88, 32'h4);
    wb(1'b1, 8'h04, 32'h40);
    wb(1'b1, 8'h00, ins(cce_pkg::OP_MODIFY, 5'h0, 24'h030000));
    wb(1'b0, 8'h4c, 32'h0);
    `CHK("index 3", 32'h140, rdat)
    wb(1'b1, 8'h00, ins(cce_pkg::OP_MODIFY, 5'h0, 24'h0b0000));
    wb(1'b0, 8'h6c, 32'h0);
    `CHK("index 11", 32'h240, rdat)
    wb(1'b1, 8'h00, ins(cce_pkg::OP_COND, 5'h1f, 24'h032000));
    wb(1'b0, 8'h4c, 32'h0);
    `CHK("post modify", 32'h144, rdat)
    // second bank selected, but the reversed form must land on index 3
    wb(1'b1, 8'h00, ins(cce_pkg::OP_REVERSE_BITS, 5'h0, 24'h0b0000));
    wb(1'b0, 8'h4c, 32'h0);
    `CHK("bit reverse", 32'h2180_0000, rdat)
    wb(1'b0, 8'h6c, 32'h0);
    `CHK("bit reverse bank", 32'h240, rdat)
    $display("done: modify");
  endtask
  task automatic t_loop;
    logic e[3] = '{1'b0, 1'b0, 1'b1};
    wb(1'b1, 8'h10, 32'h2);
    wb(1'b1, 8'h00, ins(cce_pkg::OP_COND, 5'h1d, 24'h0));
    `CHK("not expired", 1'b1, pass)
    foreach (e[i]) begin
      wb(1'b1, 8'h00, ins(cce_pkg::OP_LOOP, 5'h1c, 24'h0));
      `CHK("loop end", e[i], done)
    end
    wb(1'b1, 8'h00, ins(cce_pkg::OP_LOOP, 5'h1e, 24'h0));
    `CHK("forever", 1'b0, done)
    $display("done: loop");
  endtask
  task automatic t_misc;
    wb(1'b1, 8'h00, ins(cce_pkg::OP_IDLE, 5'h0, 24'h0));
    `CHK("idle", 1'b1, idle)
    wb(1'b1, 8'h00, ins(cce_pkg::OP_COND, 5'h1f, 24'h0));
    `CHK("idle halts", 1'b0, xfer)
    @(posedge sys_clk) wake <= 1'b1;
    @(posedge sys_clk) wake <= 1'b0;
    #1;
    `CHK("wake", 1'b0, idle)
    wb(1'b1, 8'h00, ins(cce_pkg::OP_STACK, 5'h0, 24'h600000));
    wb(1'b1, 8'h00, ins(cce_pkg::OP_STACK, 5'h0, 24'h200000));
    wb(1'b1, 8'h00, ins(cce_pkg::OP_NOP, 5'h0, 24'h0));
    wb(1'b0, 8'h0c, 32'h0);
    `CHK("no stack err", 1'b0, rdat[4])
    // popping an empty status stack must only flag, never corrupt state
    wb(1'b1, 8'h00, ins(cce_pkg::OP_STACK, 5'h0, 24'h100000));
    wb(1'b0, 8'h0c, 32'h0);
    `CHK("stack err", 1'b1, rdat[4])
    wb(1'b1, 8'h0c, 32'h10);
    wb(1'b0, 8'h0c, 32'h0);
    `CHK("err clear", 1'b0, rdat[4])
    $display("done: misc");
  endtask
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_cond();
    t_xfer();
    t_bit();
    t_mod();
    t_loop();
    t_misc();
    close_out();
  end
endmodule
